// File: rfat_ctrl.sv
`timescale 1ns/10ps
// Contract
// - block a access length picked by its two-bit speed field
// - block b access length picked by separate field, same encoding
// - speed 00 gives twelve clock periods per access
// - speed 01 gives eight clock periods per access
// - speed 10 gives five clock periods per access
// - speed 11 gives three clock periods per access
// - block b writes start only while its write enable is set; clearing it mid-access does not end the write
module rfat_ctrl (
  input  wire logic                   clk,        // 25 MHz controller clock
  input  wire logic                   nrst,       // async reset, active low
  input  wire logic [3:0]             wb_adr_i,   // wishbone byte address
  input  wire logic [31:0]            wb_dat_i,   // wishbone write data
  input  wire logic [3:0]             wb_sel_i,   // wishbone byte selects
  input  wire logic                   wb_we_i,    // wishbone write
  input  wire logic                   wb_cyc_i,   // wishbone cycle
  input  wire logic                   wb_stb_i,   // wishbone strobe
  output logic      [31:0]            wb_dat_o,   // wishbone read data
  output logic                        wb_ack_o,   // wishbone ack
  input  wire rfat_pkg::rfat_mem_req_t mem_req_i, // access request, same clock
  output logic                        mem_strobe_o, // access in progress
  output logic                        mem_we_o,   // write strobe to device
  output logic                        mem_done_o, // one-cycle access end
  output logic                        mem_blocked_o // one-cycle refused write
);

  logic [1:0]            a_spd_q;
  logic [1:0]            b_spd_q;
  logic                  b_we_q;
  logic                  blocked_sticky_q;
  logic [3:0]            cnt_q;
  rfat_pkg::rfat_state_t state_q;
  logic                  acc_b_q;
  logic                  wb_hit;
  logic                  wr_ctrl;
  logic                  wr_status;

  function automatic logic [3:0] spd_cycles(input logic [1:0] spd);
    case (spd)
      2'h0:    spd_cycles = rfat_pkg::CYC_SPD_00;
      2'h1:    spd_cycles = rfat_pkg::CYC_SPD_01;
      2'h2:    spd_cycles = rfat_pkg::CYC_SPD_10;
      default: spd_cycles = rfat_pkg::CYC_SPD_11;
    endcase
  endfunction

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl   = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == rfat_pkg::REG_CTRL_ADDR;
  assign wr_status = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == rfat_pkg::REG_STATUS_ADDR;

  // one wait state: ack the cycle after the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // control writes; byte lane 0 carries every field
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_spd_q <= rfat_pkg::SPD_RESET;
      b_spd_q <= rfat_pkg::SPD_RESET;
      b_we_q  <= rfat_pkg::B_WE_RESET;
    end else if (wr_ctrl) begin
      // no guard against mid-access change: software keeps the block idle
      a_spd_q <= wb_dat_i[rfat_pkg::CTRL_A_SPD_LSB +: 2];
      b_spd_q <= wb_dat_i[rfat_pkg::CTRL_B_SPD_LSB +: 2];
      b_we_q  <= wb_dat_i[rfat_pkg::CTRL_B_WE_BIT];
    end
  end

  // refused-write flag, cleared by writing one; a new refusal wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blocked_sticky_q <= 1'b0;
    end else if (mem_blocked_o) begin
      blocked_sticky_q <= 1'b1;
    end else if (wr_status && wb_dat_i[0]) begin
      blocked_sticky_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0;
    end else if (wb_hit && !wb_we_i) begin
      if (wb_adr_i == rfat_pkg::REG_CTRL_ADDR) begin
        wb_dat_o <= {27'h0, b_we_q, b_spd_q, a_spd_q};
      end else if (wb_adr_i == rfat_pkg::REG_STATUS_ADDR) begin
        wb_dat_o <= {29'h0, acc_b_q, state_q == rfat_pkg::RFAT_BUSY, blocked_sticky_q};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // access sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q       <= rfat_pkg::RFAT_IDLE;
      cnt_q         <= 4'h0;
      acc_b_q       <= 1'b0;
      mem_strobe_o  <= 1'b0;
      mem_we_o      <= 1'b0;
      mem_done_o    <= 1'b0;
      mem_blocked_o <= 1'b0;
    end else begin
      mem_done_o    <= 1'b0;
      mem_blocked_o <= 1'b0;
      case (state_q)
        rfat_pkg::RFAT_IDLE: begin
          if (mem_req_i.req) begin
            if (mem_req_i.blk_b && mem_req_i.we && !b_we_q) begin
              mem_blocked_o <= 1'b1;
            end else begin
              state_q      <= rfat_pkg::RFAT_BUSY;
              acc_b_q      <= mem_req_i.blk_b;
              cnt_q        <= mem_req_i.blk_b ? spd_cycles(b_spd_q)
                                              : spd_cycles(a_spd_q);
              mem_strobe_o <= 1'b1;
              mem_we_o     <= mem_req_i.we;
            end
          end
        end
        rfat_pkg::RFAT_BUSY: begin
          if (cnt_q == 4'h1) begin
            state_q      <= rfat_pkg::RFAT_DONE;
            mem_strobe_o <= 1'b0;
            mem_we_o     <= 1'b0;
            mem_done_o   <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= rfat_pkg::RFAT_IDLE;
        end
      endcase
    end
  end

  // strobe held for exactly the selected count
  logic [3:0] chk_len_q;
  logic [3:0] chk_exp_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_len_q <= 4'h0;
      chk_exp_q <= 4'h0;
    end else if (!mem_strobe_o) begin
      chk_len_q <= 4'h0;
      chk_exp_q <= mem_req_i.blk_b ? spd_cycles(b_spd_q) : spd_cycles(a_spd_q);
    end else begin
      chk_len_q <= chk_len_q + 4'h1;
    end
  end

  chk_access_len: assert property (@(posedge clk) disable iff (!nrst)
    $fell(mem_strobe_o) |-> chk_len_q == chk_exp_q)
    else $error("access length differs from speed field");

  chk_twelve_default: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && !acc_b_q && a_spd_q == 2'h0 |-> ##11 mem_strobe_o ##1 !mem_strobe_o)
    else $error("speed 00 access not twelve cycles");

  chk_three_fast: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && !acc_b_q && a_spd_q == 2'h3 |-> ##2 mem_strobe_o ##1 !mem_strobe_o)
    else $error("speed 11 access not three cycles");

  chk_eight_b: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && acc_b_q && b_spd_q == 2'h1 |-> mem_strobe_o [*8] ##1 !mem_strobe_o)
    else $error("speed 01 access not eight cycles");

  chk_five_b: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && acc_b_q && b_spd_q == 2'h2 |-> mem_strobe_o [*5] ##1 !mem_strobe_o)
    else $error("speed 10 access not five cycles");

  chk_b_write_gate: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_we_o) && acc_b_q |-> $past(b_we_q))
    else $error("block b write while disabled");

  chk_b_refuse: assert property (@(posedge clk) disable iff (!nrst)
    state_q == rfat_pkg::RFAT_IDLE && mem_req_i.req && mem_req_i.blk_b && mem_req_i.we && !b_we_q
      |=> mem_blocked_o && !mem_strobe_o ##1 blocked_sticky_q)
    else $error("disabled block b write not refused");

  chk_done_pulse: assert property (@(posedge clk) disable iff (!nrst)
    $fell(mem_strobe_o) |-> mem_done_o ##1 !mem_done_o)
    else $error("done pulse missing");

  chk_wb_ack: assert property (@(posedge clk) disable iff (!nrst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not one cycle late");

  chk_reset_vals: assert property (@(posedge clk)
    $rose(nrst) |-> a_spd_q == 2'h0 && b_spd_q == 2'h0 && !b_we_q)
    else $error("reset values not zero");

  chk_a_eight: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && !acc_b_q && a_spd_q == 2'h1 |-> mem_strobe_o [*8] ##1 !mem_strobe_o)
    else $error("block a speed 01 access not eight cycles");

  chk_a_five: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && !acc_b_q && a_spd_q == 2'h2 |-> mem_strobe_o [*5] ##1 !mem_strobe_o)
    else $error("block a speed 10 access not five cycles");

  chk_b_twelve: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && acc_b_q && b_spd_q == 2'h0 |-> ##11 mem_strobe_o ##1 !mem_strobe_o)
    else $error("block b speed 00 access not twelve cycles");

  chk_b_three: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) && acc_b_q && b_spd_q == 2'h3 |-> ##2 mem_strobe_o ##1 !mem_strobe_o)
    else $error("block b speed 11 access not three cycles");

  chk_start_len: assert property (@(posedge clk) disable iff (!nrst)
    $rose(mem_strobe_o) |-> cnt_q == chk_exp_q)
    else $error("access count not loaded from speed field");

  chk_cnt_step: assert property (@(posedge clk) disable iff (!nrst)
    state_q == rfat_pkg::RFAT_BUSY && cnt_q != 4'h1 |=> cnt_q == $past(cnt_q) - 4'h1)
    else $error("access counter skipped a step");

  chk_busy_count: assert property (@(posedge clk) disable iff (!nrst)
    state_q == rfat_pkg::RFAT_BUSY |-> cnt_q != 4'h0)
    else $error("access counter empty while busy");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
    state_q == rfat_pkg::RFAT_IDLE |-> !mem_strobe_o && !mem_we_o)
    else $error("strobe active while idle");

  chk_we_in_strobe: assert property (@(posedge clk) disable iff (!nrst)
    mem_we_o |-> mem_strobe_o)
    else $error("write strobe outside an access");

  chk_done_state: assert property (@(posedge clk) disable iff (!nrst)
    mem_done_o |-> state_q == rfat_pkg::RFAT_DONE)
    else $error("done pulse outside done state");

  chk_done_gap: assert property (@(posedge clk) disable iff (!nrst)
    mem_done_o |=> !mem_strobe_o)
    else $error("access started in the done cycle");

  chk_a_start: assert property (@(posedge clk) disable iff (!nrst)
    state_q == rfat_pkg::RFAT_IDLE && mem_req_i.req && !mem_req_i.blk_b |=> mem_strobe_o)
    else $error("block a request not started");

  chk_b_enabled: assert property (@(posedge clk) disable iff (!nrst)
    state_q == rfat_pkg::RFAT_IDLE && mem_req_i.req && mem_req_i.blk_b && (!mem_req_i.we || b_we_q)
      |=> mem_strobe_o)
    else $error("permitted block b request not started");

  chk_refuse_idle: assert property (@(posedge clk) disable iff (!nrst)
    mem_blocked_o |-> state_q == rfat_pkg::RFAT_IDLE && !mem_strobe_o)
    else $error("refused write left sequencer busy");

  chk_sticky_set: assert property (@(posedge clk) disable iff (!nrst)
    mem_blocked_o |=> blocked_sticky_q)
    else $error("refusal not recorded");

  chk_sticky_clear: assert property (@(posedge clk) disable iff (!nrst)
    wr_status && wb_dat_i[0] && !mem_blocked_o |=> !blocked_sticky_q)
    else $error("refusal flag not cleared");

  // write data of the previous edge, for the field-store check
  logic [4:0] chk_wdat_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_wdat_q <= 5'h0;
    end else begin
      chk_wdat_q <= wb_dat_i[4:0];
    end
  end

  chk_ctrl_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl |=> a_spd_q == chk_wdat_q[1:0] && b_spd_q == chk_wdat_q[3:2]
      && b_we_q == chk_wdat_q[4])
    else $error("control write not stored");

  chk_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
    wb_hit && !wb_we_i && wb_adr_i == rfat_pkg::REG_CTRL_ADDR |=> wb_dat_o == {27'h0, b_we_q, b_spd_q, a_spd_q})
    else $error("control read data wrong");

  chk_status_read: assert property (@(posedge clk) disable iff (!nrst)
    wb_hit && !wb_we_i && wb_adr_i == rfat_pkg::REG_STATUS_ADDR |=> wb_dat_o[0] == $past(blocked_sticky_q)
      && wb_dat_o[1] == ($past(state_q) == rfat_pkg::RFAT_BUSY) && wb_dat_o[2] == $past(acc_b_q))
    else $error("status read data wrong");

  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    wb_hit && !wb_we_i && wb_adr_i != rfat_pkg::REG_CTRL_ADDR && wb_adr_i != rfat_pkg::REG_STATUS_ADDR
      |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  chk_ack_pulse: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack longer than one cycle");

  chk_reset_outputs: assert property (@(posedge clk)
    $rose(nrst) |-> !mem_strobe_o && !mem_we_o && !mem_done_o && !mem_blocked_o && !wb_ack_o
      && !blocked_sticky_q && wb_dat_o == 32'h0)
    else $error("outputs not quiet after reset");

endmodule

// File: rfat_mem_model.sv
`timescale 1ns/10ps
module rfat_mem_model (
  input  wire logic       clk,    // controller clock
  input  wire logic       nrst,   // async reset, active low
  input  wire logic       strobe, // access in progress
  input  wire logic       we,     // write strobe
  output logic      [3:0] len,    // width of last access
  output logic            wrote   // last access was a write
);
  logic [3:0] cnt_q;
  // plain device: it only measures how long each access is held and whether it was a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      len   <= 4'h0;
      wrote <= 1'b0;
    end else if (strobe) begin
      cnt_q <= cnt_q + 4'h1;
      wrote <= we;
    end else if (cnt_q != 4'h0) begin
      len   <= cnt_q;
      cnt_q <= 4'h0;
    end
  end
endmodule

// File: rfat_pkg.sv
package rfat_pkg;

  // register map, word-aligned byte addresses
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;

  // control field positions
  localparam int CTRL_A_SPD_LSB = 0;
  localparam int CTRL_B_SPD_LSB = 2;
  localparam int CTRL_B_WE_BIT  = 4;

  // reset values: slowest timing, block b writes off
  localparam logic [1:0] SPD_RESET  = 2'h0;
  localparam logic       B_WE_RESET = 1'h0;

  // access lengths in controller clock periods
  localparam logic [3:0] CYC_SPD_00 = 4'hC;
  localparam logic [3:0] CYC_SPD_01 = 4'h8;
  localparam logic [3:0] CYC_SPD_10 = 4'h5;
  localparam logic [3:0] CYC_SPD_11 = 4'h3;

  typedef enum logic [1:0] {
    RFAT_IDLE = 2'b00,
    RFAT_BUSY = 2'b01,
    RFAT_DONE = 2'b11
  } rfat_state_t;

  typedef struct packed {
    logic        req;
    logic        blk_b;
    logic        we;
  } rfat_mem_req_t;

endpackage

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                    clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0;
  logic [3:0]              adr = 4'h0, len;
  logic [31:0]             dat = 32'h0, rdat, rd;
  logic                    ack, strb, mwe, done, blk, wrote;
  rfat_pkg::rfat_mem_req_t req = '0;
  logic [11:0]             rows [10];
  int                      fail_count = 0, checked = 0;
  always #20 clk = ~clk;
  rfat_ctrl u_dut (.clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mem_req_i(req), .mem_strobe_o(strb), .mem_we_o(mwe), .mem_done_o(done), .mem_blocked_o(blk));
  rfat_mem_model u_mem (.clk(clk), .nrst(nrst), .strobe(strb), .we(mwe), .len(len), .wrote(wrote));
  task automatic give_verdict();
    $display("counts: %0d checked, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("MISMATCH wb_ack expected 1 seen timeout");
    end
    @(posedge clk);
  endtask
  task automatic acc(logic b, logic w, logic [3:0] el, logic eb);
    int n;
    logic sb = 1'b0;
    req <= '{1'b1, b, w};
    for (n = 0; n < 30; n++) begin
      @(posedge clk);
      if (strb === 1'b1 || blk === 1'b1) req <= '0;
      sb |= (blk === 1'b1);
      if (done === 1'b1 || blk === 1'b1) break;
    end
    if (n >= 30) begin
      fail_count++;
      $display("MISMATCH access_end expected done seen timeout");
    end
    @(posedge clk);
    @(posedge clk);
    cmp("blocked", eb, sb);
    if (!eb) cmp("len", el, len);
    if (!eb) cmp("wrote", w, wrote);
  endtask
  // row: ctrl, block b, write, length, refused
  initial begin
    rows = '{{5'h03, 2'b00, 4'h3, 1'b0},
             {5'h01, 2'b00, 4'h8, 1'b0},
             {5'h02, 2'b00, 4'h5, 1'b0},
             {5'h0C, 2'b00, 4'hC, 1'b0},
             {5'h0C, 2'b10, 4'h3, 1'b0},
             {5'h04, 2'b10, 4'h8, 1'b0},
             {5'h08, 2'b10, 4'h5, 1'b0},
             {5'h10, 2'b11, 4'hC, 1'b0},
             {5'h00, 2'b01, 4'hC, 1'b0},
             {5'h00, 2'b11, 4'hC, 1'b1}};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(1'b0, 4'h0, 32'h0);
    cmp("ctrl_reset", 32'h0, rd);
    acc(1'b1, 1'b1, 4'hC, 1'b1);
    acc(1'b0, 1'b0, 4'hC, 1'b0);
    wb(1'b0, 4'h8, 32'h0);
    cmp("unmapped", 32'h0, rd);
    $display("test reset done");
    foreach (rows[i]) begin
      // quiet envelope of two register reads each side
      repeat (2) wb(1'b0, 4'h4, 32'h0);
      wb(1'b1, 4'h0, {27'h0, rows[i][11:7]});
      repeat (2) wb(1'b0, 4'h0, 32'h0);
      cmp("ctrl", {27'h0, rows[i][11:7]}, rd);
      acc(rows[i][6], rows[i][5], rows[i][4:1], rows[i][0]);
      $display("test row %0d done", i);
    end
    wb(1'b0, 4'h4, 32'h0);
    cmp("sticky", 32'h1, rd);
    wb(1'b1, 4'h4, 32'h1);
    wb(1'b0, 4'h4, 32'h0);
    cmp("cleared", 32'h0, rd);
    wb(1'b1, 4'h0, 32'h1F);
    wb(1'b0, 4'h0, 32'h0);
    cmp("ctrl_full", 32'h1F, rd);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(1'b0, 4'h0, 32'h0);
    cmp("ctrl_rereset", 32'h0, rd);
    wb(1'b0, 4'h4, 32'h0);
    cmp("status_rereset", 32'h0, rd);
    $display("test status and second reset done");
    give_verdict();
  end
endmodule
